// file: core/msp_ctrl.v
// Protection check and scrubbing control slice with its bus access logic.
`include "msp_regs.vh"

module msp_ctrl #(
    parameter DATA_W = 32
) (
    core_clk,
    rstn,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    selftest_data_in,
    exec_done,
    exec_op,
    test_continue_input,
    continue_counter_pulse,
    continue_counter_enable,
    resume_event,
    core_read_en,
    core_write_en,
    core_protection_select,
    mem_output_data_in,
    mem_rdata_valid,
    mem_read_enable_out,
    mem_write_enable_out,
    protection_select_out,
    protection_report_out,
    test_fail_set,
    read_trigger_exec_enable,
    uncorrectable_fail_enable,
    no_transaction_flag,
    protection_check_result,
    protection_report_enable
);
    input wire core_clk;
    input wire rstn;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [`MSP_ADDR_W-1:0] paddr;
    input wire [DATA_W-1:0] pwdata;
    output reg [DATA_W-1:0] prdata;
    output reg pready;
    output reg pslverr;
    input wire [DATA_W-1:0] selftest_data_in;
    input wire exec_done;
    input wire [`MSP_OP_W-1:0] exec_op;
    input wire test_continue_input;
    input wire continue_counter_pulse;
    input wire continue_counter_enable;
    output reg resume_event;
    input wire core_read_en;
    input wire core_write_en;
    input wire [1:0] core_protection_select;
    input wire [1:0] mem_output_data_in;
    input wire mem_rdata_valid;
    output reg mem_read_enable_out;
    output reg mem_write_enable_out;
    output reg [1:0] protection_select_out;
    output reg protection_report_out;
    output reg test_fail_set;
    output reg read_trigger_exec_enable;
    output reg uncorrectable_fail_enable;
    output reg no_transaction_flag;
    output reg [1:0] protection_check_result;
    output reg protection_report_enable;

    //=================================================================
    // Bus access states
    //=================================================================
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_WAIT = 2'b01;
    localparam [1:0] ST_DONE = 2'b10;

    reg [1:0] state_q;
    reg check_read_q;
    reg [1:0] check_data_q;

    // The control word as software sees it, reserved bits zero.
    function [DATA_W-1:0] ctrl_word;
        input rte;
        input ufe;
        input ntf;
        input [1:0] pcr;
        input pre;
        begin
            ctrl_word = {DATA_W{1'b0}};
            ctrl_word[`MSP_BIT_RTE] = rte;
            ctrl_word[`MSP_BIT_UFE] = ufe;
            ctrl_word[`MSP_BIT_NOT] = ntf;
            ctrl_word[`MSP_BIT_PCR_HI:`MSP_BIT_PCR_LO] = pcr;
            ctrl_word[`MSP_BIT_PRE] = pre;
        end
    endfunction

    wire setup_phase = psel & ~penable;
    wire access_done = psel & penable & pready;
    wire hit_ctrl = (paddr == `MSP_OFS_CTRL);
    wire hit_data = (paddr == `MSP_OFS_DATA);
    wire trig_read = setup_phase & ~pwrite & hit_data &
                     read_trigger_exec_enable;
    wire ctrl_write = access_done & pwrite & hit_ctrl;
    wire check_exec = exec_done & (exec_op == `MSP_OP_PCHK);
    wire clear_exec = exec_done & ((exec_op == `MSP_OP_LOOP_LAST) |
                                   (exec_op == `MSP_OP_CLEAR_NO_TRANSACTION_OPERATION));
    wire is_ue = check_data_q[`MSP_UE_BIT];

    //=================================================================
    // Bus slave with wait states for triggered reads
    //=================================================================
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            prdata <= {DATA_W{1'b0}};
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (trig_read) begin
                        // Ready stays low until the execution ends.
                        state_q <= ST_WAIT;
                        pready <= 1'b0;
                    end else if (setup_phase) begin
                        state_q <= ST_DONE;
                        pready <= 1'b1;
                        pslverr <= ~(hit_ctrl | hit_data);
                        if (hit_ctrl)
                            prdata <= ctrl_word(read_trigger_exec_enable,
                                uncorrectable_fail_enable,
                                no_transaction_flag,
                                protection_check_result,
                                protection_report_enable);
                        else if (hit_data)
                            prdata <= selftest_data_in;
                        else
                            prdata <= {DATA_W{1'b0}};
                    end
                end
                ST_WAIT: begin
                    if (exec_done) begin
                        // The core presents the updated word with done.
                        prdata <= selftest_data_in;
                        pready <= 1'b1;
                        pslverr <= 1'b0;
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (access_done || !psel) begin
                        pready <= 1'b0;
                        pslverr <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end

    //=================================================================
    // Advance events
    //=================================================================
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            resume_event <= 1'b0;
        end else begin
            // A triggered read is just one more continue source.
            resume_event <= test_continue_input |
                (continue_counter_pulse & continue_counter_enable) |
                trig_read;
        end
    end

    //=================================================================
    // Memory side: gating, select, report and capture
    //=================================================================
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mem_read_enable_out <= 1'b0;
            mem_write_enable_out <= 1'b0;
            protection_select_out <= `MSP_PSEL_NORMAL;
            protection_report_out <= 1'b0;
            check_read_q <= 1'b0;
            check_data_q <= `MSP_CHECK_OK;
        end else begin
            mem_read_enable_out <= core_read_en &
                                   ~no_transaction_flag;
            mem_write_enable_out <= core_write_en &
                                    ~no_transaction_flag;
            // Select 01 asks the array for its check result.
            protection_select_out <= core_protection_select;
            protection_report_out <= protection_report_enable &
                core_read_en & ~no_transaction_flag &
                (core_protection_select == `MSP_PSEL_CHECK);
            if (mem_read_enable_out)
                check_read_q <= (protection_select_out ==
                                 `MSP_PSEL_CHECK);
            if (mem_rdata_valid && check_read_q)
                check_data_q <= mem_output_data_in;
        end
    end

    //=================================================================
    // Control fields
    //=================================================================
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            read_trigger_exec_enable <= `MSP_CTRL_RST;
            uncorrectable_fail_enable <= `MSP_CTRL_RST;
            no_transaction_flag <= `MSP_CTRL_RST;
            protection_check_result <= `MSP_PCR_RST;
            protection_report_enable <= `MSP_CTRL_RST;
            test_fail_set <= 1'b0;
        end else begin
            if (ctrl_write) begin
                read_trigger_exec_enable <= pwdata[`MSP_BIT_RTE];
                uncorrectable_fail_enable <= pwdata[`MSP_BIT_UFE];
                protection_report_enable <= pwdata[`MSP_BIT_PRE];
            end
            // Hardware capture is ORed into the written value, so bits from both are kept.
            protection_check_result <=
                (ctrl_write ?
                 pwdata[`MSP_BIT_PCR_HI:`MSP_BIT_PCR_LO] :
                 protection_check_result) |
                ((mem_rdata_valid && check_read_q) ?
                 mem_output_data_in : 2'b00);
            // Set by a failed check beats both write and auto clear.
            if (check_exec && check_data_q != `MSP_CHECK_OK)
                no_transaction_flag <= 1'b1;
            else if (clear_exec)
                no_transaction_flag <= 1'b0;
            else if (ctrl_write)
                no_transaction_flag <= pwdata[`MSP_BIT_NOT];
            test_fail_set <= check_exec & is_ue &
                             uncorrectable_fail_enable;
        end
    end

endmodule // msp_ctrl

// file: core/msp_regs.vh
// Offsets, field positions, reset values and operation codes of the block.
//=====================================================================
// Operation
// - Data register read starts one execution only with trigger enabled.
// - Triggered read waits on the bus until done, then returns new data.
// - Triggered read advances the test like a continue pulse.
// - With fail enable, check uncorrectable error sets test fail flag.
// - Memory output bit 1 means uncorrectable, only on select 01 reads.
// - No-transaction flag forces memory enables low; it resets clear.
// - Check operation with output data not 01 sets no-transaction flag.
// - Result field ORs in output bits 1:0 of select 01 reads.
// - Report output high on select 01 reads only when report enabled.
// - Select 01 requests the parity or error check result from memory.
// - Enabled continue counter pulse raises a resume event.
//=====================================================================
`ifndef MSP_REGS_VH
`define MSP_REGS_VH

`define MSP_ADDR_W 12
`define MSP_OFS_CTRL 12'h000
`define MSP_OFS_DATA 12'h004

`define MSP_BIT_RTE 22
`define MSP_BIT_UFE 21
`define MSP_BIT_NOT 20
`define MSP_BIT_PCR_HI 19
`define MSP_BIT_PCR_LO 18
`define MSP_BIT_PRE 17

`define MSP_CTRL_RST 1'b0
`define MSP_PCR_RST 2'b00

`define MSP_PSEL_NORMAL 2'b00
`define MSP_PSEL_CHECK 2'b01
`define MSP_CHECK_OK 2'b01
`define MSP_UE_BIT 1

`define MSP_OP_W 3
`define MSP_OP_PCHK 3'h1
`define MSP_OP_LOOP_LAST 3'h2
`define MSP_OP_CLEAR_NO_TRANSACTION_OPERATION 3'h3

`endif

// file: verif/msp_ctrl_properties.sv
// Checker of the protection and scrubbing slice port behaviour.
module msp_ctrl_properties (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic exec_done,
    input wire logic [2:0] exec_op,
    input wire logic core_read_en,
    input wire logic [1:0] core_protection_select,
    input wire logic mem_read_enable_out,
    input wire logic mem_write_enable_out,
    input wire logic protection_report_out,
    input wire logic test_fail_set,
    input wire logic read_trigger_exec_enable,
    input wire logic uncorrectable_fail_enable,
    input wire logic no_transaction_flag,
    input wire logic protection_report_enable,
    input wire logic resume_event
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==================================================================
    // Properties
    wire rd_setup = psel && !penable && !pwrite && paddr == 12'h004;
    wire chk_rd = core_read_en && core_protection_select == 2'b01;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_trigger_starts: assert property (rd_setup && read_trigger_exec_enable
        |=> resume_event && !pready)
        else $error("triggered read did not start");
    a_trigger_waits: assert property (pready && paddr == 12'h004 && !pwrite
        && read_trigger_exec_enable |-> $past(exec_done))
        else $error("triggered read ended early");
    a_nop_gating: assert property ($past(no_transaction_flag)
        |-> !mem_read_enable_out && !mem_write_enable_out)
        else $error("access not suppressed");
    a_read_passes: assert property (core_read_en && !no_transaction_flag
        |=> mem_read_enable_out)
        else $error("read enable lost");
    a_report_cause: assert property (protection_report_out
        |-> $past(protection_report_enable && chk_rd))
        else $error("report without cause");
    a_report_when: assert property (protection_report_enable && chk_rd
        && !no_transaction_flag |=> protection_report_out)
        else $error("report missing");
    a_fail_cause: assert property (test_fail_set |-> $past(exec_done
        && exec_op == 3'h1 && uncorrectable_fail_enable))
        else $error("fail without cause");
    a_clear_flag: assert property (exec_done && exec_op[1]
        |=> !no_transaction_flag)
        else $error("flag not cleared");
endmodule // msp_ctrl_properties

bind msp_ctrl msp_ctrl_properties i_msp_ctrl_properties (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready),
    .exec_done(exec_done), .exec_op(exec_op), .core_read_en(core_read_en),
    .core_protection_select(core_protection_select),
    .mem_read_enable_out(mem_read_enable_out),
    .mem_write_enable_out(mem_write_enable_out),
    .protection_report_out(protection_report_out),
    .test_fail_set(test_fail_set),
    .read_trigger_exec_enable(read_trigger_exec_enable),
    .uncorrectable_fail_enable(uncorrectable_fail_enable),
    .no_transaction_flag(no_transaction_flag),
    .protection_report_enable(protection_report_enable),
    .resume_event(resume_event));

// file: verif/msp_mem_model.sv
// Memory side model that answers protection check reads.
module msp_mem_model (
    input wire logic core_clk,
    input wire logic read_en,
    input wire logic [1:0] sel,
    input wire logic [1:0] chk_value,
    output logic [1:0] rdata = 2'h0,
    output logic valid = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // Data toggles outside valid cycles so a stale value never passes.
    always @(posedge core_clk) begin
        valid <= read_en && sel == 2'b01;
        rdata <= (read_en && sel == 2'b01) ? chk_value : ~rdata;
    end
endmodule // msp_mem_model

// file: verif/msp_ctrl_tb.sv
// Self-checking bench of the protection and scrubbing slice.
module msp_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, st_data = 32'h1234_5678;
    logic exec_done = 0, tci = 0, ccp = 0, cce = 0, c_rd = 0, c_wr = 0;
    logic [2:0] exec_op = 0;
    logic [1:0] c_sel = 0, mdat, chk_value = 0, psel_o, pcr;
    logic pready, pslverr, resume, mvalid, m_rd, m_wr, rep, tfs;
    logic rte, ufe, ntf, pre;
    int mismatches = 0, checked = 0, cycles = 0, fails = 0, resumes = 0;
    always #10 core_clk = ~core_clk;
    msp_ctrl i_msp_ctrl (.core_clk(core_clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .selftest_data_in(st_data), .exec_done(exec_done), .exec_op(exec_op),
        .test_continue_input(tci), .continue_counter_pulse(ccp),
        .continue_counter_enable(cce), .resume_event(resume),
        .core_read_en(c_rd), .core_write_en(c_wr),
        .core_protection_select(c_sel), .mem_output_data_in(mdat),
        .mem_rdata_valid(mvalid), .mem_read_enable_out(m_rd),
        .mem_write_enable_out(m_wr), .protection_select_out(psel_o),
        .protection_report_out(rep), .test_fail_set(tfs),
        .read_trigger_exec_enable(rte), .uncorrectable_fail_enable(ufe),
        .no_transaction_flag(ntf), .protection_check_result(pcr),
        .protection_report_enable(pre));
    msp_mem_model i_msp_mem_model (.core_clk(core_clk), .read_en(m_rd),
        .sel(psel_o), .chk_value(chk_value), .rdata(mdat), .valid(mvalid));
    // ==================================================================
    // Tasks
    task automatic check(input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input int d);
        int n = 0;
        @(negedge core_clk);
        {psel, pwrite, paddr, pwdata} = {1'b1, wr, a, d};
        @(negedge core_clk);
        penable = 1;
        do @(posedge core_clk); while (pready !== 1'b1 && ++n < 200);
        rd = prdata;
        @(negedge core_clk);
        {psel, penable} = 2'b00;
    endtask
    task automatic pulse(input int kind, input logic [2:0] op);
        @(negedge core_clk);
        {exec_done, exec_op, c_rd, c_wr, c_sel, ccp} = kind == 0 ? {4'h8 | op,
            5'h00} : kind == 1 ? {4'h0, 5'h12} : {4'h0, 5'h01};
        @(negedge core_clk);
        {exec_done, c_rd, c_wr, ccp} = 4'h0;
        repeat (4) @(negedge core_clk);
    endtask
    task automatic close_out;
        if (mismatches == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        resumes += resume;
        fails += tfs;
        if (cycles == 3000) begin
            mismatches++;
            close_out;
        end
    end
    // ==================================================================
    // Sequence
    initial begin
        repeat (16) @(negedge core_clk);
        rstn = 1;
        apb(0, 12'h000, 0);
        check(rd, 0);
        apb(1, 12'h000, 32'h007E_0000);
        apb(0, 12'h000, 0);
        check(rd, 32'h007E_0000);
        apb(1, 12'h000, 32'h0040_0000);
        fork
            apb(0, 12'h004, 0);
            begin
                // Done must come while the read is already waiting.
                repeat (3) @(negedge core_clk);
                pulse(0, 3'h0);
            end
        join
        check(rd, st_data);
        check(resumes, 1);
        apb(1, 12'h000, 0);
        apb(0, 12'h004, 0);
        check(resumes, 1);
        cce = 1;
        pulse(2, 3'h0);
        check(resumes, 2);
        apb(1, 12'h000, 32'h0022_0000);
        chk_value = 2'b11;
        pulse(1, 3'h0);
        pulse(0, 3'h1);
        check({fails, ntf, pcr}, 15);
        pulse(1, 3'h0);
        pulse(0, 3'h3);
        check(ntf, 0);
        apb(1, 12'h000, 32'h0002_0000);
        chk_value = 2'b10;
        pulse(1, 3'h0);
        pulse(0, 3'h1);
        check({fails, ntf, pcr}, 14);
        pulse(0, 3'h2);
        chk_value = 2'b01;
        pulse(1, 3'h0);
        pulse(0, 3'h1);
        check({ntf, pcr}, 3);
        close_out;
    end
endmodule // msp_ctrl_tb
